// ### rtl/cpj_pkg.sv
/*
  shared types and constants of the device control block: option carrier,
  test access port states and controls, data register kinds.
  assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package cpj_pkg;

  // global design options, fixed by the configuration pattern
  typedef struct packed {
    logic auto_standby;
    logic pd_en_a;
    logic pd_en_b;
    logic keeper_en;
    logic jtag_en;
    logic security_fuse;
  } cpj_opts_t;

  // test access port controller states
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } cpj_tap_t;

  // decoded state flags, acted on at the test clock rising edge
  typedef struct packed {
    logic tlr;
    logic cap_dr;
    logic sh_dr;
    logic upd_dr;
    logic cap_ir;
    logic sh_ir;
    logic upd_ir;
  } cpj_tap_ctl_t;

  // data register selected by the current instruction
  typedef enum logic [2:0] {
    DR_BYP, DR_BSR, DR_ID, DR_PROG, DR_VER, DR_SIG
  } cpj_dr_t;

  localparam int ID_W = 32;
  localparam int SIG_W = 16;
  localparam int BYP_W = 1;
  localparam logic [1:0] IR_CAP_LOW = 2'h1;
  localparam logic [31:0] ID_LSB = 32'h0000_0001;

endpackage
`default_nettype wire

// ### rtl/cpj_tap.sv
/*
  test access port state machine, advanced on detected test clock edges.
  assumes tms already synchronised and a one-cycle rise pulse from the
  caller; there is no test reset pin, so only nrst_i and a clear force
  the reset state.
*/
`default_nettype none
module cpj_tap (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic tck_rise_i,
  input wire logic tms_i,
  input wire logic tap_clr_i,
  output cpj_pkg::cpj_tap_t state_o,
  output cpj_pkg::cpj_tap_ctl_t ctl_o
);

  cpj_pkg::cpj_tap_t state_reg;
  cpj_pkg::cpj_tap_t state_next;

  // next state from tms, standard boundary-scan graph
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cpj_pkg::TLR: state_next = tms_i ? cpj_pkg::TLR : cpj_pkg::RTI;
      cpj_pkg::RTI: state_next = tms_i ? cpj_pkg::SEL_DR : cpj_pkg::RTI;
      cpj_pkg::SEL_DR: state_next = tms_i ? cpj_pkg::SEL_IR : cpj_pkg::CAP_DR;
      cpj_pkg::CAP_DR: state_next = tms_i ? cpj_pkg::EX1_DR : cpj_pkg::SH_DR;
      cpj_pkg::SH_DR: state_next = tms_i ? cpj_pkg::EX1_DR : cpj_pkg::SH_DR;
      cpj_pkg::EX1_DR: state_next = tms_i ? cpj_pkg::UPD_DR : cpj_pkg::PA_DR;
      cpj_pkg::PA_DR: state_next = tms_i ? cpj_pkg::EX2_DR : cpj_pkg::PA_DR;
      cpj_pkg::EX2_DR: state_next = tms_i ? cpj_pkg::UPD_DR : cpj_pkg::SH_DR;
      cpj_pkg::UPD_DR: state_next = tms_i ? cpj_pkg::SEL_DR : cpj_pkg::RTI;
      cpj_pkg::SEL_IR: state_next = tms_i ? cpj_pkg::TLR : cpj_pkg::CAP_IR;
      cpj_pkg::CAP_IR: state_next = tms_i ? cpj_pkg::EX1_IR : cpj_pkg::SH_IR;
      cpj_pkg::SH_IR: state_next = tms_i ? cpj_pkg::EX1_IR : cpj_pkg::SH_IR;
      cpj_pkg::EX1_IR: state_next = tms_i ? cpj_pkg::UPD_IR : cpj_pkg::PA_IR;
      cpj_pkg::PA_IR: state_next = tms_i ? cpj_pkg::EX2_IR : cpj_pkg::PA_IR;
      cpj_pkg::EX2_IR: state_next = tms_i ? cpj_pkg::UPD_IR : cpj_pkg::SH_IR;
      cpj_pkg::UPD_IR: state_next = tms_i ? cpj_pkg::SEL_DR : cpj_pkg::RTI;
      default: state_next = cpj_pkg::TLR;
    endcase
  end

  // power-up reset and disabled port both park the controller
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= cpj_pkg::TLR;
    end else if (tap_clr_i) begin
      state_reg <= cpj_pkg::TLR;
    end else if (tck_rise_i) begin
      state_reg <= state_next;
    end
  end

  // state flags for the register logic
  always_comb begin
    ctl_o.tlr = (state_reg == cpj_pkg::TLR);
    ctl_o.cap_dr = (state_reg == cpj_pkg::CAP_DR);
    ctl_o.sh_dr = (state_reg == cpj_pkg::SH_DR);
    ctl_o.upd_dr = (state_reg == cpj_pkg::UPD_DR);
    ctl_o.cap_ir = (state_reg == cpj_pkg::CAP_IR);
    ctl_o.sh_ir = (state_reg == cpj_pkg::SH_IR);
    ctl_o.upd_ir = (state_reg == cpj_pkg::UPD_IR);
  end

  assign state_o = state_reg;

endmodule
`default_nettype wire

// ### rtl/cpj_ctrl.sv
/*
  device-level control: standby, power-down hold, per-cell power options,
  slew selection, power-up output levels, readback security, and the
  four-pin test port with boundary scan and programming session guard.
  assumes pins arrive unsynchronised and the test clock is far slower
  than ref_clk_i; core_out_i and core_oe_i come from the macrocell array, core_in_o goes to it.
*/
`default_nettype none
module cpj_ctrl #(
  parameter int NPINS = 16,
  parameter int CFG_W = 32,
  parameter int IR_LEN = 4,
  parameter int TCK_IDX = 0,
  parameter int TMS_IDX = 1,
  parameter int TDI_IDX = 2,
  parameter int TDO_IDX = 3,
  parameter int PDA_IDX = 4,
  parameter int PDB_IDX = 5,
  parameter logic [IR_LEN-1:0] OP_EXTEST = 4'h0,
  parameter logic [IR_LEN-1:0] OP_SAMPLE = 4'h1,
  parameter logic [IR_LEN-1:0] OP_IDCODE = 4'h2,
  parameter logic [IR_LEN-1:0] OP_HIGHZ = 4'h3,
  parameter logic [IR_LEN-1:0] OP_PROG = 4'h4,
  parameter logic [IR_LEN-1:0] OP_VERIFY = 4'h5,
  parameter logic [IR_LEN-1:0] OP_SIG = 4'h6,
  parameter logic [IR_LEN-1:0] OP_BYPASS = 4'hf,
  // arbitrary identification value, lsb must stay one
  parameter logic [31:0] IDCODE_VAL = 32'h0a5a_5001,
  parameter logic [NPINS-1:0] OUT_POL = '0
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire cpj_pkg::cpj_opts_t opts_i,
  input wire logic [NPINS-1:0] reduced_power_i,
  input wire logic [NPINS-1:0] mc_off_i,
  input wire logic [NPINS-1:0] slew_fast_i,
  input wire logic [NPINS-1:0] core_out_i,
  input wire logic [NPINS-1:0] core_oe_i,
  input wire logic [CFG_W-1:0] cfg_pattern_i,
  input wire logic [cpj_pkg::SIG_W-1:0] user_sig_i,
  input wire logic [NPINS-1:0] pin_i,
  output logic [NPINS-1:0] pin_o,
  output logic [NPINS-1:0] pin_oe_o,
  output logic [NPINS-1:0] slew_fast_o,
  output logic [NPINS-1:0] core_in_o,
  output logic standby_o,
  output logic power_down_o,
  output logic keeper_en_o,
  output logic [NPINS-1:0] keeper_level_o,
  output logic prog_wr_o,
  output logic [CFG_W-1:0] prog_data_o,
  output logic prog_session_o,
  output logic locked_o
);

  localparam int W_A = (CFG_W > NPINS) ? CFG_W : NPINS;
  localparam int DR_W = (W_A > cpj_pkg::ID_W) ? W_A : cpj_pkg::ID_W;

  logic [NPINS-1:0] s1_reg, s2_reg, s3_reg, pin_s_reg;
  logic tck_prev_reg, tck_lvl, tck_rise, tck_fall, tck_rise_ok;
  cpj_pkg::cpj_tap_t tap_state;
  cpj_pkg::cpj_tap_ctl_t ctl;
  logic [IR_LEN-1:0] ir_sh_reg, ir_reg;
  logic [DR_W-1:0] dr_sh_reg, cap_val, dr_shifted;
  cpj_pkg::cpj_dr_t cur_dr;
  int cur_len;
  logic [NPINS-1:0] bsr_upd_reg;
  logic [CFG_W-1:0] prog_data_reg;
  logic prog_wr_reg, tdo_reg, tdo_en;
  logic session_reg, lock_reg, interrupt;
  logic pd_req, pd_reg, hold;
  logic [NPINS-1:0] ded, rp_reg, eff_out, drv_out, drv_oe;
  logic [NPINS-1:0] pin_o_reg, pin_oe_reg, core_in_reg, keep_reg;
  logic [NPINS-1:0] slew_reg, pin_prev_reg, core_prev_reg;
  logic standby_reg, activity;

  // instruction to data register; unknown opcodes fall to bypass
  function automatic cpj_pkg::cpj_dr_t dr_sel(input logic [IR_LEN-1:0] op);
    case (op)
      OP_EXTEST, OP_SAMPLE: dr_sel = cpj_pkg::DR_BSR;
      OP_IDCODE: dr_sel = cpj_pkg::DR_ID;
      OP_PROG: dr_sel = cpj_pkg::DR_PROG;
      OP_VERIFY: dr_sel = cpj_pkg::DR_VER;
      OP_SIG: dr_sel = cpj_pkg::DR_SIG;
      default: dr_sel = cpj_pkg::DR_BYP;
    endcase
  endfunction

  // length of the selected register in bits
  function automatic int dr_len(input cpj_pkg::cpj_dr_t kind);
    case (kind)
      cpj_pkg::DR_BSR: dr_len = NPINS;
      cpj_pkg::DR_ID: dr_len = cpj_pkg::ID_W;
      cpj_pkg::DR_PROG, cpj_pkg::DR_VER: dr_len = CFG_W;
      cpj_pkg::DR_SIG: dr_len = cpj_pkg::SIG_W;
      default: dr_len = cpj_pkg::BYP_W;
    endcase
  endfunction

  // three-stage pin synchroniser; level moves once stages two and three agree
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      pin_s_reg <= '0;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      pin_s_reg <= (s3_reg & ~(s2_reg ^ s3_reg)) |
                   (pin_s_reg & (s2_reg ^ s3_reg));
    end
  end

  // test clock edges; a disabled port never sees a rise, only one fall if disabled while tck is high
  assign tck_lvl = pin_s_reg[TCK_IDX] & opts_i.jtag_en;
  assign tck_rise = tck_lvl & ~tck_prev_reg;
  assign tck_fall = ~tck_lvl & tck_prev_reg;
  assign tck_rise_ok = tck_rise & ~hold;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tck_prev_reg <= 1'b0;
    end else begin
      tck_prev_reg <= tck_lvl;
    end
  end

  cpj_tap u_tap (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .tck_rise_i(tck_rise_ok),
    .tms_i(pin_s_reg[TMS_IDX]),
    .tap_clr_i(~opts_i.jtag_en),
    .state_o(tap_state),
    .ctl_o(ctl)
  );

  // instruction register; reset state selects identification
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ir_sh_reg <= '0;
      ir_reg <= OP_IDCODE;
    end else if (tck_rise_ok) begin
      if (ctl.tlr) begin
        ir_reg <= OP_IDCODE;
      end else if (ctl.cap_ir) begin
        ir_sh_reg <= IR_LEN'(cpj_pkg::IR_CAP_LOW);
      end else if (ctl.sh_ir) begin
        ir_sh_reg <= {pin_s_reg[TDI_IDX], ir_sh_reg[IR_LEN-1:1]};
      end else if (ctl.upd_ir) begin
        ir_reg <= ir_sh_reg;
      end
    end
  end

  assign cur_dr = dr_sel(ir_reg);
  assign cur_len = dr_len(cur_dr);
  assign dr_shifted = {1'b0, dr_sh_reg[DR_W-1:1]};

  // capture values; the fuse blanks pattern readback only
  always_comb begin
    case (cur_dr)
      cpj_pkg::DR_BSR: cap_val = DR_W'(pin_s_reg);
      cpj_pkg::DR_ID: cap_val = DR_W'(IDCODE_VAL | cpj_pkg::ID_LSB);
      cpj_pkg::DR_PROG: cap_val = DR_W'(prog_data_reg);
      cpj_pkg::DR_VER: cap_val = opts_i.security_fuse ? '0 :
                                 DR_W'(cfg_pattern_i);
      cpj_pkg::DR_SIG: cap_val = DR_W'(user_sig_i);
      default: cap_val = '0;
    endcase
  end

  // shared data shifter; tdi enters at the top bit of the selected length
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dr_sh_reg <= '0;
    end else if (tck_rise_ok && ctl.cap_dr) begin
      dr_sh_reg <= cap_val;
    end else if (tck_rise_ok && ctl.sh_dr) begin
      for (int i = 0; i < DR_W; i++) begin
        dr_sh_reg[i] <= (i == cur_len - 1) ? pin_s_reg[TDI_IDX] :
                        dr_shifted[i];
      end
    end
  end

  // update stage: scan drive values and programming words
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bsr_upd_reg <= '0;
      prog_data_reg <= '0;
      prog_wr_reg <= 1'b0;
    end else begin
      prog_wr_reg <= 1'b0;
      if (tck_rise_ok && ctl.upd_dr) begin
        if (cur_dr == cpj_pkg::DR_BSR) begin
          bsr_upd_reg <= dr_sh_reg[NPINS-1:0];
        end
        if (cur_dr == cpj_pkg::DR_PROG) begin
          prog_data_reg <= dr_sh_reg[CFG_W-1:0];
          prog_wr_reg <= 1'b1;
        end
      end
    end
  end

  // tdo changes on the falling test clock edge, as the protocol expects
  assign tdo_en = ctl.sh_dr | ctl.sh_ir;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tdo_reg <= 1'b0;
    end else if (tck_fall) begin
      tdo_reg <= ctl.sh_ir ? ir_sh_reg[0] : dr_sh_reg[0];
    end
  end

  // session opens on loading the programming opcode; any way out other
  // than a fresh instruction counts as an interruption and locks until reset
  assign interrupt = session_reg &
                     (~opts_i.jtag_en || tap_state == cpj_pkg::TLR);
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      session_reg <= 1'b0;
      lock_reg <= 1'b0;
    end else if (interrupt) begin
      session_reg <= 1'b0;
      lock_reg <= 1'b1;
    end else if (tck_rise_ok && ctl.upd_ir) begin
      session_reg <= (ir_sh_reg == OP_PROG);
    end
  end

  // power-down request from either enabled pin
  assign pd_req = (opts_i.pd_en_a & pin_s_reg[PDA_IDX]) |
                  (opts_i.pd_en_b & pin_s_reg[PDB_IDX]);
  assign hold = pd_req;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pd_reg <= 1'b0;
    end else begin
      pd_reg <= pd_req;
    end
  end

  // pins claimed by the test port or power-down control
  always_comb begin
    ded = '0;
    if (opts_i.jtag_en) begin
      ded[TCK_IDX] = 1'b1;
      ded[TMS_IDX] = 1'b1;
      ded[TDI_IDX] = 1'b1;
      ded[TDO_IDX] = 1'b1;
    end
    ded[PDA_IDX] = ded[PDA_IDX] | opts_i.pd_en_a;
    ded[PDB_IDX] = ded[PDB_IDX] | opts_i.pd_en_b;
  end

  // reduced-power cells take one extra cycle on the output path
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rp_reg <= '0;
    end else if (!hold) begin
      rp_reg <= core_out_i;
    end
  end
  assign eff_out = (reduced_power_i & rp_reg) |
                   (~reduced_power_i & core_out_i);

  // per-pin drive selection, highest priority first
  for (genvar g = 0; g < NPINS; g++) begin : g_pin
    always_comb begin
      if (ded[g]) begin
        drv_out[g] = (g == TDO_IDX) ? tdo_reg & opts_i.jtag_en : 1'b0;
        drv_oe[g] = (g == TDO_IDX) ? tdo_en & opts_i.jtag_en : 1'b0;
      end else if (lock_reg || session_reg) begin
        drv_out[g] = 1'b0;
        drv_oe[g] = 1'b0;
      end else if (ir_reg == OP_HIGHZ) begin
        drv_out[g] = 1'b0;
        drv_oe[g] = 1'b0;
      end else if (ir_reg == OP_EXTEST) begin
        drv_out[g] = bsr_upd_reg[g];
        drv_oe[g] = 1'b1;
      end else if (mc_off_i[g]) begin
        drv_out[g] = 1'b0;
        drv_oe[g] = 1'b0;
      end else begin
        drv_out[g] = eff_out[g];
        drv_oe[g] = core_oe_i[g];
      end
    end
  end

  // pin registers; frozen while powered down, polarity level at reset
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_o_reg <= OUT_POL;
      pin_oe_reg <= '0;
    end else if (!hold) begin
      pin_o_reg <= drv_out;
      pin_oe_reg <= drv_oe;
    end
  end

  // inputs to the array: held in power-down and through programming
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      core_in_reg <= '0;
      keep_reg <= '0;
    end else begin
      if (!hold && !session_reg) begin
        core_in_reg <= pin_s_reg & ~ded & ~mc_off_i;
      end
      if (!hold && !session_reg && !lock_reg) begin
        keep_reg <= pin_s_reg;
      end
    end
  end

  // standby needs one cycle with no toggle on any pin or array output; cheap but jittery
  assign activity = |(pin_s_reg ^ pin_prev_reg) |
                    |(core_out_i ^ core_prev_reg);
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_prev_reg <= '0;
      core_prev_reg <= '0;
      standby_reg <= 1'b0;
      slew_reg <= '0;
    end else begin
      pin_prev_reg <= pin_s_reg;
      core_prev_reg <= core_out_i;
      standby_reg <= opts_i.auto_standby & ~activity & ~pd_req;
      slew_reg <= slew_fast_i;
    end
  end

  assign pin_o = pin_o_reg;
  assign pin_oe_o = pin_oe_reg;
  assign slew_fast_o = slew_reg;
  assign core_in_o = core_in_reg;
  assign standby_o = standby_reg;
  assign power_down_o = pd_reg;
  assign keeper_en_o = opts_i.keeper_en;
  assign keeper_level_o = keep_reg;
  assign prog_wr_o = prog_wr_reg;
  assign prog_data_o = prog_data_reg;
  assign prog_session_o = session_reg;
  assign locked_o = lock_reg;

  // checks on the control paths
  lock_hiz_a: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) lock_reg && !hold |=> (pin_oe_o & ~ded) == '0)
    else $error("locked device drives a user pin");
  pd_entry_a: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i)
    opts_i.pd_en_a && $rose(pin_s_reg[PDA_IDX]) |=> power_down_o)
    else $error("power-down not entered");
  pd_hold_a: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i)
    pd_req ##1 pd_req |-> $stable(pin_o) && $stable(core_in_o))
    else $error("outputs moved during power-down");
  // pin a is the power-down pin that the scenarios enable
  pd_pin_a: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) opts_i.pd_en_a ##1 opts_i.pd_en_a && !hold
    |=> !pin_oe_o[PDA_IDX] && !core_in_o[PDA_IDX])
    else $error("power-down pin used as logic");
  fuse_read_a: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) tck_rise_ok && ctl.cap_dr &&
    cur_dr == cpj_pkg::DR_VER && opts_i.security_fuse |=> dr_sh_reg == '0)
    else $error("protected pattern read back");
  id_lsb_a: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i)
    tck_rise_ok && ctl.cap_dr && cur_dr == cpj_pkg::DR_ID
    |=> dr_sh_reg[0] && dr_sh_reg[31:1] == IDCODE_VAL[31:1])
    else $error("identification capture wrong");
  tlr_ir_a: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) tck_rise_ok && ctl.tlr |=> ir_reg == OP_IDCODE)
    else $error("reset state lost identification opcode");
  // a disabled port parks the controller and its pins follow the array
  jtag_off_a: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) !opts_i.jtag_en && !hold && !lock_reg &&
    !session_reg && ir_reg != OP_HIGHZ && ir_reg != OP_EXTEST &&
    !mc_off_i[TDO_IDX] |=> tap_state == cpj_pkg::TLR &&
    pin_oe_o[TDO_IDX] == $past(core_oe_i[TDO_IDX]))
    else $error("disabled port still active");
  standby_a: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) activity |=> !standby_o)
    else $error("standby despite activity");
  bypass_a: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i)
    tck_rise_ok && ctl.cap_dr && cur_dr == cpj_pkg::DR_BYP
    |=> dr_sh_reg[0] == 1'b0)
    else $error("bypass capture not zero");

  pd_seen_c: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
    $rose(power_down_o));
  prog_wr_c: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
    prog_session_o && prog_wr_o);
  lock_c: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
    $rose(locked_o));
  extest_c: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
    ir_reg == OP_EXTEST && tck_rise_ok && ctl.upd_dr);

endmodule
`default_nettype wire

// ### test/cpj_host.sv
/*
  test port programmer model driving clock, mode select and data in.
  assumes the device turns data out around within half a clock period.
*/
`default_nettype none
module cpj_host (
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // clock parked low between frames, never free running
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // one 125 ns period; data out taken just before the rise
  task automatic tick(input logic ms, input logic di, output logic d);
    tms_o = ms;
    tdi_o = di;
    #62.5;
    d = tdo_i;
    tck_o = 1'b1;
    #62.5;
    tck_o = 1'b0;
  endtask
  // idle, one ir or dr scan lsb first, back to idle
  task automatic scan(input logic ir, input logic [31:0] din, input int n,
                      output logic [31:0] dout);
    logic d;
    dout = '0;
    tick(1'b1, 1'b0, d);
    if (ir) begin
      tick(1'b1, 1'b0, d);
    end
    tick(1'b0, 1'b0, d);
    tick(1'b0, 1'b0, d);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], d);
      dout[i] = d;
    end
    tick(1'b1, ~din[n-1], d);
    tick(1'b0, ~din[n-1], d);
    // released data line shows the last bit again, not its inverse
    tdi_o = ~tdi_o;
  endtask
  // five mode-high clocks reach reset from any state, then idle
  task automatic reset_tap();
    logic d;
    repeat (5) tick(1'b1, 1'b0, d);
    tick(1'b0, 1'b0, d);
  endtask
endmodule
`default_nettype wire

// ### test/test_cpj_power_down_and_jtag_isp_control.sv
/*
  bench for the device control block: pin table, scan, power-down, lock.
  assumes cpj_host on pins 0..2, data out read back from pin 3.
*/
`default_nettype none
module test_cpj_power_down_and_jtag_isp_control;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] ID_V = 32'h1234_5671; // arbitrary, lsb one
  localparam logic [15:0] USR_M = 16'hffc0;
  typedef struct packed {
    logic [15:0] slew, cout, coe, off, rp, o, oe;
  } cpj_row_t;
  cpj_row_t rows [4] = '{
    '{16'h0000, 16'hffc0, 16'hffc0, 16'h0000, 16'h0000, 16'hffc0, 16'hffc0},
    '{16'hffff, 16'h5540, 16'hffc0, 16'h0000, 16'h0000, 16'h5540, 16'hffc0},
    '{16'h00c0, 16'hffc0, 16'hffc0, 16'h0f00, 16'h0000, 16'hf0c0, 16'hf0c0},
    '{16'h0000, 16'haa80, 16'h0fc0, 16'h0000, 16'hffc0, 16'h0a80, 16'h0fc0}};
  logic ref_clk_i, nrst_i, tck, tms, tdi, pd_a, stby, pdn, keep_en, pwr;
  logic sess, lock, seen;
  cpj_pkg::cpj_opts_t opts;
  logic [15:0] rp, off, slew, cout, coe, usr, pin_o, pin_oe, slew_o, core_in;
  logic [15:0] keep_lvl, sig, pin_i, k;
  logic [31:0] cfg, pdata, prog_data, got;
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  int pw_n = 0;
  // pin 3 reads back its own drive, inverse while released
  assign pin_i = {usr[15:6], 1'b0, pd_a, pin_o[3] ^ ~pin_oe[3], tdi, tms, tck};
  cpj_host host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(pin_i[3]));
  cpj_ctrl #(.IDCODE_VAL(ID_V)) uut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .opts_i(opts), .reduced_power_i(rp), .mc_off_i(off), .slew_fast_i(slew),
    .core_out_i(cout), .core_oe_i(coe), .cfg_pattern_i(cfg),
    .user_sig_i(sig), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe),
    .slew_fast_o(slew_o), .core_in_o(core_in), .standby_o(stby),
    .power_down_o(pdn), .keeper_en_o(keep_en), .keeper_level_o(keep_lvl),
    .prog_wr_o(pwr), .prog_data_o(prog_data), .prog_session_o(sess),
    .locked_o(lock));
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // hang guard; full run needs about 3800 cycles
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches = mismatches + 1;
      results();
    end
    if (pwr === 1'b1) begin
      pdata <= prog_data;
      pw_n <= pw_n + 1;
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    opts = '0;
    opts.jtag_en = 1'b1;
    {rp, off, slew, cout, coe, usr} = '0;
    cfg = 32'h3c3c_a5a5;
    sig = 16'hbeef;
    pd_a = 1'b0;
    nrst_i = 1'b0;
    wt(16);
    chk(pin_oe, 16'h0000);
    chk(pin_o, 16'h0000);
    nrst_i = 1'b1;
    wt(2);
    chk(slew_o, 16'h0000);
    chk(lock, 1'b0);
    done("reset");
    // table of ordinary pin cases
    foreach (rows[i]) begin
      slew = rows[i].slew;
      cout = rows[i].cout;
      coe = rows[i].coe;
      off = rows[i].off;
      rp = rows[i].rp;
      usr = cout ^ 16'h0f00;
      wt(8);
      chk(pin_o & rows[i].oe & USR_M, rows[i].o);
      chk(pin_oe & USR_M, rows[i].oe);
      chk(slew_o & USR_M, slew & USR_M);
      chk(core_in & USR_M, usr & USR_M);
      done("row");
    end
    // reduced-power cells follow the array one cycle late
    cout = 16'h5540;
    wt(1);
    chk(pin_o & 16'h0fc0, 16'h0a80);
    wt(1);
    chk(pin_o & 16'h0fc0, 16'h0540);
    rp = '0;
    opts.jtag_en = 1'b0;
    coe = 16'hffff;
    wt(8);
    chk(pin_oe[3:0], 4'hf);
    opts.jtag_en = 1'b1;
    opts.auto_standby = 1'b1;
    wt(8);
    chk(stby, 1'b1);
    usr = ~usr;
    seen = 1'b1;
    repeat (8) begin
      wt(1);
      seen = seen & stby;
    end
    chk(seen, 1'b0);
    opts.auto_standby = 1'b0;
    done("standby");
    host.reset_tap();
    host.scan(1'b0, '0, 32, got);
    chk(got, ID_V);
    host.scan(1'b1, 32'h0000_000f, 4, got);
    chk(got[1:0], cpj_pkg::IR_CAP_LOW);
    host.scan(1'b0, 32'h0000_00b5, 8, got);
    chk(got[7:0], 8'h6a);
    host.scan(1'b1, 32'h0000_0003, 4, got);
    wt(4);
    chk(pin_oe & USR_M, 16'h0000);
    host.scan(1'b1, 32'h0000_0006, 4, got);
    host.scan(1'b0, '0, 16, got);
    chk(got[15:0], sig);
    host.scan(1'b1, 32'h0000_0005, 4, got);
    host.scan(1'b0, '0, 32, got);
    chk(got, cfg);
    opts.security_fuse = 1'b1;
    host.scan(1'b0, '0, 32, got);
    chk(got, 32'h0000_0000);
    opts.security_fuse = 1'b0;
    done("scan");
    host.scan(1'b1, 32'h0000_0001, 4, got);
    host.scan(1'b0, 32'h0000_a5c0, 16, got);
    chk(got[15:0] & USR_M, usr & USR_M);
    host.scan(1'b1, 32'h0000_0000, 4, got);
    wt(4);
    chk(pin_o & USR_M, 16'ha5c0 & USR_M);
    chk(pin_oe & USR_M, USR_M);
    host.scan(1'b1, 32'h0000_000f, 4, got);
    done("boundary");
    opts.pd_en_a = 1'b1;
    cout = 16'hffc0;
    coe = USR_M;
    wt(8);
    pd_a = 1'b1;
    wt(8);
    chk(pdn, 1'b1);
    k = core_in;
    cout = 16'h0000;
    usr = ~usr;
    wt(8);
    chk(pin_o & USR_M, 16'hffc0);
    chk(core_in, k);
    chk(core_in[4], 1'b0);
    pd_a = 1'b0;
    wt(8);
    chk(pdn, 1'b0);
    chk(pin_o & USR_M, 16'h0000);
    done("power-down");
    opts.keeper_en = 1'b1;
    host.scan(1'b1, 32'h0000_0004, 4, got);
    chk(sess, 1'b1);
    chk(keep_en, 1'b1);
    k = keep_lvl;
    usr = ~usr;
    wt(8);
    chk(keep_lvl & USR_M, k & USR_M);
    host.scan(1'b0, 32'hc0de_1234, 32, got);
    wt(2);
    chk(pdata, 32'hc0de_1234);
    chk(pw_n, 1);
    host.reset_tap();
    wt(2);
    chk(lock, 1'b1);
    chk(sess, 1'b0);
    chk(pin_oe & USR_M, 16'h0000);
    done("program");
    results();
  end
endmodule
`default_nettype wire
